// ---- verilog/dma_engine.sv ----
// Two-channel DMA engine: channel registers, request logic and bus sequencer.
// Assumes a bus slave that answers each cycle with a one-clock busDone.
// How it works
// - Memory and I/O in any direction
// - Wide bus: bytes or words, no byte-memory words
// - Narrow bus: bytes only
// - Read then write, eight clocks least
// - Request pin, Timer 2 or software
// - Programmable priority picks the next transfer, never preempts
// - Two addresses, count, control per channel
// - Up to 64K transfers, then stop if bit 9 is set
// - Registers writable anytime, effective immediately
// - Bit 15: destination memory or I/O
// - Bits 14-13: destination step mode
// - Bit 12: source memory or I/O
// - Bits 11-10: source step mode
// - Bit 9: stop at terminal count
// - Bit 8: interrupt on last transfer
// - Bits 7-6: request synchronization mode
// - Bit 5: priority over other channel
// - Bit 4: accept Timer 2 requests
// - Bit 0: byte or word transfers
// - DMA beats CPU except odd-word, locked
// - Maskable ignored, NMI halts DMA
// - Serial port usable as either end
module dma_engine
    import dma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Peripheral register block port
    input wire logic [dma_pkg::REG_AW-1:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [dma_pkg::DATA_W-1:0] regWdata,
    output logic [dma_pkg::DATA_W-1:0] regRdata,
    // Request sources
    input wire logic [dma_pkg::NUM_CH-1:0] channelRequestInputs,
    input wire logic timer2Evt,
    input wire logic nmiReq,
    // CPU bus conditions and straps
    input wire logic cpuOddWord,
    input wire logic cpuLocked,
    input wire logic narrowBus,
    input wire logic memByteOnly,
    // System bus master
    output logic dmaHold,
    output logic busCycle,
    output logic busWrite,
    output logic busIo,
    output logic busWord,
    output logic [dma_pkg::ADDR_W-1:0] busAddr,
    output logic [dma_pkg::DATA_W-1:0] busWdata,
    input wire logic busDone,
    input wire logic [dma_pkg::DATA_W-1:0] busRdata,
    // Last-transfer interrupt requests
    output logic [dma_pkg::NUM_CH-1:0] dmaIrq
);
    typedef struct packed {
        phase_t phase;
        logic [NUM_CH-1:0][ADDR_W-1:0] src;
        logic [NUM_CH-1:0][ADDR_W-1:0] dst;
        logic [NUM_CH-1:0][DATA_W-1:0] count;
        logic [NUM_CH-1:0][DATA_W-1:0] ctrl;
        logic [NUM_CH-1:0] tmrPend;
        logic ch;
        logic word;
        logic [3:0] cyc;
        logic [DATA_W-1:0] rdata;
        logic hold;
        logic cycle;
        logic write;
        logic io;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [NUM_CH-1:0] irq;
    } dma_state_t;

    dma_state_t st, next_st;

    logic [NUM_CH-1:0] reqPend;
    logic [NUM_CH-1:0] prio;
    logic pick;
    logic anyReq;
    logic bufInValid;
    logic bufInReady;
    logic bufOutValid;
    logic bufOutReady;
    logic [DATA_W-1:0] bufOutData;
    logic regHit;
    logic regCh;
    logic [3:0] regOff;
    logic cpuBlock;
    logic xferWord;
    logic finish;

    function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0] m,
                                                   input logic w);
        logic [ADDR_W-1:0] d;
        d = w ? ADDR_WORD_STEP : ADDR_BYTE_STEP;
        if (m == STEP_INC)
        begin
            return a + d;
        end
        else if (m == STEP_DEC)
        begin
            return a - d;
        end
        return a;
    endfunction

    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_req
            assign reqPend[i] = st.ctrl[i][CB_START] &&
                ((st.ctrl[i][CB_SYNC_HI:CB_SYNC_LO] == SYNC_NONE) ||
                 channelRequestInputs[i] || st.tmrPend[i]);
            assign prio[i] = st.ctrl[i][CB_PRIO];
        end
    endgenerate

    dma_arbiter u_arb (
        .pend(reqPend),
        .prio(prio),
        .pick(pick),
        .any(anyReq)
    );

    dma_buffer u_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inData(busRdata),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outData(bufOutData)
    );

    assign regCh = (regAddr[7:4] == CH1_BASE);
    assign regOff = regAddr[3:0];
    assign regHit = ((regAddr[7:4] == CH0_BASE) || (regAddr[7:4] == CH1_BASE)) &&
                    !regOff[0] && (regOff <= OFF_CTRL);
    // Odd-word and locked CPU cycles keep the bus
    assign cpuBlock = cpuOddWord || cpuLocked;
    // Word only where bus and memory allow
    assign xferWord = st.ctrl[pick][CB_WORD] && !narrowBus &&
        !(memByteOnly && st.ctrl[pick][CB_DST_MEM]) &&
        !(memByteOnly && st.ctrl[pick][CB_SRC_MEM]);
    // Write done and eight clocks spent
    assign finish = (st.phase == ST_WRITE) && st.write && !st.cycle &&
                    (st.cyc >= MIN_XFER_CLKS - 4'h1);

    always_comb
    begin
        next_st = st;
        next_st.irq = '0;
        bufInValid = 1'b0;
        bufOutReady = 1'b0;
        if (st.cyc != CYC_MAX && st.phase != ST_IDLE)
        begin
            next_st.cyc = st.cyc + 4'h1;
        end
        unique case (st.phase)
            ST_IDLE:
            begin
                // NMI stops new transfers; maskable requests never do
                if (anyReq && !nmiReq && !cpuBlock && bufInReady)
                begin
                    next_st.ch = pick;
                    next_st.word = xferWord;
                    next_st.hold = 1'b1;
                    next_st.cycle = 1'b1;
                    next_st.write = 1'b0;
                    next_st.addr = st.src[pick];
                    next_st.io = !st.ctrl[pick][CB_SRC_MEM];
                    next_st.cyc = '0;
                    next_st.phase = ST_READ;
                    next_st.tmrPend[pick] = 1'b0;
                end
            end
            ST_READ:
            begin
                if (busDone)
                begin
                    next_st.cycle = 1'b0;
                    bufInValid = 1'b1;
                    next_st.phase = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                // NMI frees the bus between cycles
                next_st.hold = !nmiReq;
                if (!st.cycle && !st.write && bufOutValid && !nmiReq)
                begin
                    next_st.cycle = 1'b1;
                    next_st.write = 1'b1;
                    next_st.addr = st.dst[st.ch];
                    next_st.io = !st.ctrl[st.ch][CB_DST_MEM];
                    next_st.wdata = bufOutData;
                end
                if (st.cycle && busDone)
                begin
                    next_st.cycle = 1'b0;
                    bufOutReady = 1'b1;
                end
                if (finish)
                begin
                    next_st.src[st.ch] = stepAddr(st.src[st.ch],
                        st.ctrl[st.ch][CB_SRC_STEP_HI:CB_SRC_STEP_LO], st.word);
                    next_st.dst[st.ch] = stepAddr(st.dst[st.ch],
                        st.ctrl[st.ch][CB_DST_STEP_HI:CB_DST_STEP_LO], st.word);
                    // Sixteen-bit count, wraps when not stopping
                    next_st.count[st.ch] = st.count[st.ch] - COUNT_ONE;
                    if (st.count[st.ch] == COUNT_ONE)
                    begin
                        if (st.ctrl[st.ch][CB_TC_STOP])
                        begin
                            next_st.ctrl[st.ch][CB_START] = 1'b0;
                        end
                        next_st.irq[st.ch] = st.ctrl[st.ch][CB_LAST_IRQ];
                    end
                    next_st.write = 1'b0;
                    next_st.hold = 1'b0;
                    next_st.phase = ST_IDLE;
                end
            end
            default:
            begin
                next_st.phase = ST_IDLE;
            end
        endcase
        // Timer 2 latched when enabled; set beats consume
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (timer2Evt && st.ctrl[i][CB_TMR_EN])
            begin
                next_st.tmrPend[i] = 1'b1;
            end
        end
        // Software write wins over engine update
        if (regWr && regHit)
        begin
            unique case (regOff)
                OFF_SRC_LO: next_st.src[regCh][15:0] = regWdata;
                OFF_SRC_HI: next_st.src[regCh][19:16] = regWdata[3:0];
                OFF_DST_LO: next_st.dst[regCh][15:0] = regWdata;
                OFF_DST_HI: next_st.dst[regCh][19:16] = regWdata[3:0];
                OFF_COUNT: next_st.count[regCh] = regWdata;
                default: next_st.ctrl[regCh] = regWdata;
            endcase
        end
        if (regRd)
        begin
            next_st.rdata = '0;
            if (regHit)
            begin
                unique case (regOff)
                    OFF_SRC_LO: next_st.rdata = st.src[regCh][15:0];
                    OFF_SRC_HI: next_st.rdata = {12'h000, st.src[regCh][19:16]};
                    OFF_DST_LO: next_st.rdata = st.dst[regCh][15:0];
                    OFF_DST_HI: next_st.rdata = {12'h000, st.dst[regCh][19:16]};
                    OFF_COUNT: next_st.rdata = st.count[regCh];
                    default: next_st.rdata = st.ctrl[regCh];
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.phase <= ST_IDLE;
            st.src <= {NUM_CH{ADDR_RESET}};
            st.dst <= {NUM_CH{ADDR_RESET}};
            st.count <= {NUM_CH{COUNT_RESET}};
            st.ctrl <= {NUM_CH{CTRL_RESET}};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Serial port is just an I/O address at either end
    assign regRdata = st.rdata;
    assign dmaHold = st.hold;
    assign busCycle = st.cycle;
    assign busWrite = st.write;
    assign busIo = st.io;
    assign busWord = st.word;
    assign busAddr = st.addr;
    assign busWdata = st.wdata;
    assign dmaIrq = st.irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    xfer_min_len_a: assert property (
        st.phase == ST_IDLE && next_st.phase == ST_READ |=> (st.phase != ST_IDLE)[*8])
        else $error("transfer shorter than eight clocks");

    write_after_read_a: assert property (
        busCycle && busWrite |-> st.phase == ST_WRITE)
        else $error("write cycle outside write phase");

    count_step_a: assert property (
        finish && !regWr |=> st.count[$past(st.ch)] == $past(st.count[st.ch]) - COUNT_ONE)
        else $error("count not decremented");

    tc_stop_a: assert property (
        finish && !regWr && st.count[st.ch] == COUNT_ONE && st.ctrl[st.ch][CB_TC_STOP]
        |=> !st.ctrl[$past(st.ch)][CB_START] ##1
            !(st.phase == ST_READ && st.ch == $past(st.ch, 2)))
        else $error("channel kept running at terminal count");

    last_irq_a: assert property (
        $rose(dmaIrq[0]) |-> $past(finish) && $past(st.ctrl[0][CB_LAST_IRQ]) ##1 !dmaIrq[0])
        else $error("interrupt without enabled last transfer");

    nmi_halt_a: assert property (
        nmiReq && st.phase == ST_IDLE |=> st.phase == ST_IDLE && !dmaHold)
        else $error("transfer started during nmi");

    cpu_yield_a: assert property (
        cpuBlock && st.phase == ST_IDLE |=> st.phase == ST_IDLE)
        else $error("bus taken from odd-word or locked cpu");

    narrow_byte_a: assert property (
        narrowBus && $rose(busCycle) |-> !busWord)
        else $error("word transfer on narrow bus");

    dst_space_a: assert property (
        $rose(busCycle && busWrite) |-> busIo == !$past(st.ctrl[st.ch][CB_DST_MEM]))
        else $error("destination space wrong");
endmodule

// ---- verilog/dma_pkg.sv ----
// Constants shared by the two-channel DMA engine and its helpers.
// Assumes a single 40 MHz clock and byte offsets inside the peripheral block.
package dma_pkg;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned REG_AW = 8;
    localparam int unsigned NUM_CH = 2;
    // Least clocks per transfer, read and write together
    localparam logic [3:0] MIN_XFER_CLKS = 4'h8;
    localparam logic [3:0] CYC_MAX = 4'hf;

    // Channel register groups in the peripheral register block
    localparam logic [3:0] CH0_BASE = 4'hc;
    localparam logic [3:0] CH1_BASE = 4'hd;
    localparam logic [3:0] OFF_SRC_LO = 4'h0;
    localparam logic [3:0] OFF_SRC_HI = 4'h2;
    localparam logic [3:0] OFF_DST_LO = 4'h4;
    localparam logic [3:0] OFF_DST_HI = 4'h6;
    localparam logic [3:0] OFF_COUNT = 4'h8;
    localparam logic [3:0] OFF_CTRL = 4'ha;
    localparam logic [7:0] CHANNEL0_CONTROL_WORD = 8'hca;
    localparam logic [7:0] CHANNEL1_CONTROL_WORD = 8'hda;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [19:0] ADDR_RESET = 20'h00000;

    // Control word fields
    localparam int unsigned CB_DST_MEM = 15;
    localparam int unsigned CB_DST_STEP_HI = 14;
    localparam int unsigned CB_DST_STEP_LO = 13;
    localparam int unsigned CB_SRC_MEM = 12;
    localparam int unsigned CB_SRC_STEP_HI = 11;
    localparam int unsigned CB_SRC_STEP_LO = 10;
    localparam int unsigned CB_TC_STOP = 9;
    localparam int unsigned CB_LAST_IRQ = 8;
    localparam int unsigned CB_SYNC_HI = 7;
    localparam int unsigned CB_SYNC_LO = 6;
    localparam int unsigned CB_PRIO = 5;
    localparam int unsigned CB_TMR_EN = 4;
    localparam int unsigned CB_START = 1;
    localparam int unsigned CB_WORD = 0;

    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [19:0] ADDR_BYTE_STEP = 20'h00001;
    localparam logic [19:0] ADDR_WORD_STEP = 20'h00002;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} phase_t;
endpackage

// ---- verilog/dma_arbiter.sv ----
// Picks the channel to serve next from the pending requests.
// Assumes it is consulted only between transfers.
module dma_arbiter
    import dma_pkg::*;
(
    // Requests and programmed priorities
    input wire logic [dma_pkg::NUM_CH-1:0] pend,
    input wire logic [dma_pkg::NUM_CH-1:0] prio,
    // Decision
    output logic pick,
    output logic any
);
    always_comb
    begin
        any = |pend;
        pick = 1'b0;
        if (pend[1] && (!pend[0] || (prio[1] && !prio[0])))
        begin
            pick = 1'b1;
        end
    end
endmodule

// ---- verilog/dma_buffer.sv ----
// Two-entry buffer between the read and write halves of a transfer.
// Assumes the producer honours inReady and the consumer outValid.
module dma_buffer
    import dma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [dma_pkg::DATA_W-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [dma_pkg::DATA_W-1:0] outData
);
    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } buf_state_t;

    buf_state_t st, next_st;

    assign inReady = (st.cnt != 2'h2);
    assign outValid = (st.cnt != 2'h0);
    assign outData = st.mem[st.rd];

    always_comb
    begin
        next_st = st;
        if (inValid && inReady)
        begin
            next_st.mem[st.wr] = inData;
            next_st.wr = ~st.wr;
        end
        if (outValid && outReady)
        begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = st.cnt + {1'b0, inValid && inReady} - {1'b0, outValid && outReady};
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ---- dv/bus_slave_model.sv ----
// Memory and I/O space seen by the engine on the system bus.
// Assumes busCycle drops the cycle after busDone; lat adds wait states.
module bus_slave_model
    import dma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Bus cycle from the engine
    input wire logic busCycle,
    input wire logic busWrite,
    input wire logic [dma_pkg::ADDR_W-1:0] busAddr,
    // Wait states and answer
    input wire logic [1:0] lat,
    output logic busDone,
    output logic [dma_pkg::DATA_W-1:0] busRdata
);
    import dma_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] waitCnt;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitCnt <= 2'h0;
            busDone <= 1'b0;
            busRdata <= 16'h0000;
        end
        else
        begin
            busDone <= 1'b0;
            // Outside an answer the data toggles, so a stale word is never read
            busRdata <= ~busRdata;
            if (busCycle && !busDone)
            begin
                if (waitCnt >= lat)
                begin
                    busDone <= 1'b1;
                    waitCnt <= 2'h0;
                    if (!busWrite)
                        busRdata <= {busAddr[7:0] ^ 8'h5a, busAddr[7:0]};
                end
                else
                    waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the two-channel DMA engine.
// Assumes the bus slave model answers every bus cycle of the engine.
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dma_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regWdata = 16'h0000;
    logic [15:0] regRdata;
    logic [1:0] channelRequestInputs = 2'h0;
    logic timer2Evt = 1'b0;
    logic nmiReq = 1'b0;
    logic cpuOddWord = 1'b0;
    logic cpuLocked = 1'b0;
    logic narrowBus = 1'b0;
    logic memByteOnly = 1'b0;
    logic [1:0] lat = 2'h0;
    logic dmaHold, busCycle, busWrite, busIo, busWord, busDone;
    logic [19:0] busAddr;
    logic [15:0] busWdata, busRdata;
    logic [1:0] dmaIrq;
    logic [38:0] busLog[$];
    int mismatches = 0;
    int nChecks = 0;
    int cycles = 0;
    int holdLen = 0;
    int irqCnt[2] = '{0, 0};
    logic [31:0] seed = 32'h00000018;

    dma_engine i_dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
        .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
        .channelRequestInputs(channelRequestInputs), .timer2Evt(timer2Evt), .nmiReq(nmiReq),
        .cpuOddWord(cpuOddWord), .cpuLocked(cpuLocked), .narrowBus(narrowBus),
        .memByteOnly(memByteOnly), .dmaHold(dmaHold), .busCycle(busCycle),
        .busWrite(busWrite), .busIo(busIo), .busWord(busWord), .busAddr(busAddr),
        .busWdata(busWdata), .busDone(busDone), .busRdata(busRdata), .dmaIrq(dmaIrq));
    bus_slave_model i_mem (.ref_clk(ref_clk), .rstn(rstn), .busCycle(busCycle),
        .busWrite(busWrite), .busAddr(busAddr), .lat(lat), .busDone(busDone),
        .busRdata(busRdata));

    always #12.5 ref_clk = ~ref_clk;

    task automatic results();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bus log, transfer length, interrupt pulses and the hang limit
    always @(posedge ref_clk)
    begin
        cycles++;
        if (busDone && busCycle)
            busLog.push_back({busWrite, busIo, busWord, busAddr, busWrite ? busWdata : busRdata});
        for (int c = 0; c < 2; c++)
            if (dmaIrq[c])
                irqCnt[c]++;
        if (dmaHold)
            holdLen++;
        else if (holdLen != 0)
        begin
            `CHK(holdLen >= 8, 1'b1)
            holdLen = 0;
        end
        if (cycles == 60000)
        begin
            mismatches++;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] mem(input logic [19:0] a);
        return {a[7:0] ^ 8'h5a, a[7:0]};
    endfunction
    function automatic logic [19:0] step(input logic [19:0] a, input logic [1:0] m, input logic w);
        if (m == 2'h1)
            return a + (w ? 20'h2 : 20'h1);
        if (m == 2'h2)
            return a - (w ? 20'h2 : 20'h1);
        return a;
    endfunction
    function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
        return {ch ? CH1_BASE : CH0_BASE, off};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask
    task automatic prog(input int ch, input logic [19:0] sa, input logic [19:0] da,
                        input logic [15:0] cnt, input logic [15:0] ctl);
        wr(ra(ch, OFF_CTRL), 16'h0000);
        wr(ra(ch, OFF_SRC_LO), sa[15:0]);
        wr(ra(ch, OFF_SRC_HI), {12'h000, sa[19:16]});
        wr(ra(ch, OFF_DST_LO), da[15:0]);
        wr(ra(ch, OFF_DST_HI), {12'h000, da[19:16]});
        wr(ra(ch, OFF_COUNT), cnt);
        wr(ra(ch, OFF_CTRL), ctl);
    endtask
    task automatic xfer(input int ch, input logic [19:0] sa, input logic [19:0] da,
                        input logic [15:0] cnt, input logic [15:0] ctl);
        logic w;
        int t;
        int irq0;
        irq0 = irqCnt[ch];
        busLog.delete();
        prog(ch, sa, da, cnt, ctl);
        w = ctl[CB_WORD] && !narrowBus && !(memByteOnly && (ctl[CB_SRC_MEM] || ctl[CB_DST_MEM]));
        t = 0;
        while (busLog.size() < 2 * cnt && t < 600)
        begin
            @(posedge ref_clk);
            t++;
        end
        repeat (16) @(posedge ref_clk);
        `CHK(busLog.size(), 2 * cnt)
        for (int i = 0; i < cnt && 2 * i + 1 < busLog.size(); i++)
        begin
            `CHK(busLog[2 * i], {1'b0, !ctl[CB_SRC_MEM], w, sa, mem(sa)})
            `CHK(busLog[2 * i + 1], {1'b1, !ctl[CB_DST_MEM], w, da, mem(sa)})
            sa = step(sa, ctl[11:10], w);
            da = step(da, ctl[14:13], w);
        end
        `CHK(irqCnt[ch] - irq0, int'(ctl[CB_LAST_IRQ]))
        rdChk(ra(ch, OFF_COUNT), 16'h0000);
        rdChk(ra(ch, OFF_SRC_LO), sa[15:0]);
        rdChk(ra(ch, OFF_DST_HI), {12'h000, da[19:16]});
    endtask

    initial
    begin
        logic [31:0] r, r2;
        int n;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        #1 `CHK({dmaHold, busCycle, dmaIrq}, 4'h0)
        rdChk(CHANNEL0_CONTROL_WORD, CTRL_RESET);
        wr(ra(1, OFF_SRC_HI), 16'hffff);
        rdChk(ra(1, OFF_SRC_HI), 16'h000f);
        wr(CHANNEL1_CONTROL_WORD, 16'ha5a0);
        rdChk(CHANNEL1_CONTROL_WORD, 16'ha5a0);
        wr(8'hc1, 16'h1234);
        rdChk(8'hc1, 16'h0000);
        rdChk(8'hb0, 16'h0000);
        // Directions and step modes walk through i; addresses, count, word, interrupt and bus straps are random
        for (int i = 0; i < 32; i++)
        begin
            r = rnd();
            r2 = rnd();
            narrowBus <= r[20] & r[21];
            memByteOnly <= r[22];
            lat <= r[25:24];
            xfer(i % 2, r[19:0], r2[19:0], {14'h0, r[27:26]} + 16'h1,
                 {i[0], i[3:2], i[1], i[4:3], 1'b1, r[8], 6'h00, 1'b1, r[0]});
        end
        lat <= 2'h0;
        for (int p = 0; p < 3; p++)
        begin
            busLog.delete();
            prog(0, 20'h01000, 20'h02000, 16'h0001, (p == 2) ? 16'h9262 : 16'h9242);
            prog(1, 20'h05000, 20'h06000, 16'h0001, (p == 1) ? 16'h9262 : 16'h9242);
            @(posedge ref_clk);
            channelRequestInputs <= 2'h3;
            repeat (60) @(posedge ref_clk);
            channelRequestInputs <= 2'h0;
            `CHK(busLog.size(), 4)
            `CHK(busLog[0][35:16], (p == 1) ? 20'h05000 : 20'h01000)
        end
        for (int j = 0; j < 2; j++)
        begin
            busLog.delete();
            prog(0, 20'h00700, 20'h00800, 16'h0001, j ? 16'h9252 : 16'h9242);
            @(posedge ref_clk);
            timer2Evt <= 1'b1;
            @(posedge ref_clk);
            timer2Evt <= 1'b0;
            repeat (40) @(posedge ref_clk);
            `CHK(busLog.size(), 2 * j)
        end
        for (int k = 0; k < 3; k++)
        begin
            busLog.delete();
            nmiReq <= (k == 0);
            cpuLocked <= (k == 1);
            cpuOddWord <= (k == 2);
            prog(0, 20'h00100, 20'h00200, 16'h0001, 16'h9202);
            repeat (20) @(posedge ref_clk);
            `CHK(busLog.size(), 0)
            {nmiReq, cpuLocked, cpuOddWord} <= 3'h0;
            repeat (40) @(posedge ref_clk);
            `CHK(busLog.size(), 2)
        end
        // Without the stop bit the run goes on past zero until control is cleared
        busLog.delete();
        n = irqCnt[0];
        prog(0, 20'h00300, 20'h00400, 16'h0001, 16'h9102);
        repeat (60) @(posedge ref_clk);
        `CHK(busLog.size() > 2, 1'b1)
        `CHK(irqCnt[0] - n, 1)
        wr(CHANNEL0_CONTROL_WORD, 16'h0000);
        repeat (20) @(posedge ref_clk);
        n = busLog.size();
        repeat (30) @(posedge ref_clk);
        `CHK(busLog.size(), n)
        results();
    end
endmodule
